// ==== rtl/ifb_bank.sv ====
// Interrupt flag and enable bank with APB register access.
// Assumes event inputs are one-cycle pulses synchronous to CLK.
//
// Implementation choices: the register offsets and the APB interface to the registers.
module ifb_bank #(
    parameter int LARGE = 0
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Event sources
    input wire logic [ifb_pkg::NPIN-1:0] EXT_PIN,
    input wire logic [1:0] CMP_EVT,
    input wire logic ADC_EVT,
    input wire logic [1:0] TB_EVT,
    input wire logic [ifb_pkg::NMF-1:0] MF_EVT,
    // Requests to the core and system interrupt
    output logic CPU_IRQ,
    output logic [ifb_pkg::NSRC-1:0] CPU_IRQ_VEC,
    output logic IRQ
);
    import ifb_pkg::*;

    // Only the two documented layouts can be served
    generate
        if (LARGE != 0 && LARGE != 1) begin : g_chk
            $error("LARGE must be 0 or 1");
        end
    endgenerate

    localparam ifb_map_t MAP = (LARGE != 0) ? MAP_LARGE : MAP_SMALL;
    localparam logic [NSRC-1:0] PRESENT = (LARGE != 0) ? PRESENT_LARGE : PRESENT_SMALL;
    localparam logic [7:0] EDGE_MASK = (LARGE != 0) ? 8'hff : 8'h0f;

    logic [7:0] edge_reg;
    logic gie_reg;
    logic [NSRC-1:0] flag_reg;
    logic [NSRC-1:0] flag_next;
    logic [NSRC-1:0] en_reg;
    logic [NSRC-1:0] en_next;
    logic [NSRC-1:0] stat_reg;
    logic [NSRC-1:0] ien_reg;
    logic [31:0] prdata_reg;
    logic [NPIN-1:0] pin_s1_reg;
    logic [NPIN-1:0] pin_s2_reg;
    logic [NPIN-1:0] pin_s3_reg;
    logic [NPIN-1:0] pin_det;
    logic [NPIN-1:0] pin_edge_reg;
    logic [NSRC-1:0] hw_set;
    logic [NSRC-1:0] sw_wf;
    logic [NSRC-1:0] sw_fv;
    logic [NSRC-1:0] sw_we;
    logic [NSRC-1:0] sw_ev;
    logic setup;
    logic wr_acc;
    logic mapped;
    logic [3:0] sel;
    logic [7:0] wbyte;

    // Bus phases; zero wait states keep the core's access short
    assign setup = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign wbyte = PWDATA[7:0];
    assign PREADY = 1'b1;
    assign PRDATA = prdata_reg;

    // Address decode of the four control registers
    assign sel[0] = (PADDR == ADDR_FIRST);
    assign sel[1] = (PADDR == ADDR_SECOND);
    assign sel[2] = (PADDR == ADDR_THIRD);
    assign sel[3] = (PADDR == ADDR_FOURTH) && (LARGE != 0);

    // Unmapped offsets answer with an error in the access phase
    always_comb begin
        case (PADDR)
            ADDR_EDGE, ADDR_FIRST, ADDR_SECOND, ADDR_THIRD,
            ADDR_STAT, ADDR_CLR, ADDR_IEN: mapped = 1'b1;
            ADDR_FOURTH: mapped = (LARGE != 0);
            default: mapped = 1'b0;
        endcase
    end
    assign PSLVERR = PSEL && PENABLE && !mapped;

    // Build one control byte from the slot map
    function automatic logic [7:0] ctrl_byte(
        input int r,
        input logic [NSRC-1:0] f,
        input logic [NSRC-1:0] e,
        input logic g
    );
        logic [7:0] b;
        logic [3:0] s;
        b = 8'h00;
        for (int k = 0; k < 4; k++) begin
            s = MAP[r][k];
            if (s != SRC_NONE) begin
                b[FLAG_LSB + k] = f[s];
                if (r == 0) begin
                    b[FIRST_EN_LSB + k] = e[s];
                end else begin
                    b[EN_LSB + k] = e[s];
                end
            end
        end
        if (r == 0) begin
            b[GIE_BIT] = g;
            b[7] = 1'b0;
        end
        return b;
    endfunction

    // Software writes routed to sources through the slot map
    always_comb begin
        sw_wf = '0;
        sw_fv = '0;
        sw_we = '0;
        sw_ev = '0;
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 4; k++) begin
                if (wr_acc && sel[r] && MAP[r][k] != SRC_NONE) begin
                    sw_wf[MAP[r][k]] = 1'b1;
                    sw_fv[MAP[r][k]] = wbyte[FLAG_LSB + k];
                    sw_we[MAP[r][k]] = 1'b1;
                    if (r == 0) begin
                        sw_ev[MAP[r][k]] = wbyte[FIRST_EN_LSB + k];
                    end else begin
                        sw_ev[MAP[r][k]] = wbyte[EN_LSB + k];
                    end
                end
            end
        end
    end

    // Read data captured in the setup cycle, held through access
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup) begin
            prdata_reg <= 32'h0000_0000;
            case (PADDR)
                ADDR_EDGE: prdata_reg[7:0] <= edge_reg;
                ADDR_FIRST: prdata_reg[7:0] <= ctrl_byte(0, flag_reg, en_reg, gie_reg);
                ADDR_SECOND: prdata_reg[7:0] <= ctrl_byte(1, flag_reg, en_reg, gie_reg);
                ADDR_THIRD: prdata_reg[7:0] <= ctrl_byte(2, flag_reg, en_reg, gie_reg);
                ADDR_FOURTH: prdata_reg[7:0] <= ctrl_byte(3, flag_reg, en_reg, gie_reg);
                ADDR_STAT: prdata_reg[NSRC-1:0] <= stat_reg;
                ADDR_IEN: prdata_reg[NSRC-1:0] <= ien_reg;
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Edge select; upper fields only exist in the large variant
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            edge_reg <= REG_RST;
        end else if (wr_acc && PADDR == ADDR_EDGE) begin
            edge_reg <= wbyte & EDGE_MASK;
        end
    end

    // Global enable; bit 7 of the first register has no storage
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            gie_reg <= 1'b0;
        end else if (wr_acc && sel[0]) begin
            gie_reg <= wbyte[GIE_BIT];
        end
    end

    // Pin sampling chain; s1 only feeds s2
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
        end else begin
            pin_s1_reg <= EXT_PIN;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // Per-pin edge qualifier from its two-bit field
    generate
        for (genvar p = 0; p < NPIN; p++) begin : g_pin
            logic rise;
            logic fall;
            logic [1:0] fld;
            assign fld = edge_reg[2*p +: 2];
            assign rise = pin_s2_reg[p] && !pin_s3_reg[p];
            assign fall = !pin_s2_reg[p] && pin_s3_reg[p];
            always_comb begin
                case (fld)
                    EDGE_RISE: pin_det[p] = rise;
                    EDGE_FALL: pin_det[p] = fall;
                    EDGE_BOTH: pin_det[p] = rise || fall;
                    default: pin_det[p] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Detected edge registered; the flag follows a cycle later
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pin_edge_reg <= '0;
        end else begin
            pin_edge_reg <= pin_det;
        end
    end

    // Hardware set vector in source order, absent sources dropped
    assign hw_set = {MF_EVT, TB_EVT, ADC_EVT, CMP_EVT, pin_edge_reg} & PRESENT;

    // Flag and enable next values; a hardware set beats a software clear
    generate
        for (genvar i = 0; i < NSRC; i++) begin : g_src
            assign flag_next[i] = PRESENT[i] &&
                ((sw_wf[i] ? sw_fv[i] : flag_reg[i]) || hw_set[i]);
            assign en_next[i] = PRESENT[i] && (sw_we[i] ? sw_ev[i] : en_reg[i]);
        end
    endgenerate

    // Request flags
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            flag_reg <= SRC_RST;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Source enables
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            en_reg <= SRC_RST;
        end else begin
            en_reg <= en_next;
        end
    end

    // Sticky event status; write-one-to-clear, set wins
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            stat_reg <= SRC_RST;
        end else if (wr_acc && PADDR == ADDR_CLR) begin
            stat_reg <= (stat_reg & ~PWDATA[NSRC-1:0]) | hw_set;
        end else begin
            stat_reg <= stat_reg | hw_set;
        end
    end

    // Status interrupt enables
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ien_reg <= SRC_RST;
        end else if (wr_acc && PADDR == ADDR_IEN) begin
            ien_reg <= PWDATA[NSRC-1:0];
        end
    end

    // Core request vector needs flag and enable; CPU_IRQ also needs the global enable
    assign CPU_IRQ_VEC = flag_reg & en_reg;
    assign CPU_IRQ = gie_reg && (|CPU_IRQ_VEC);
    // System interrupt level from sticky status
    assign IRQ = |(stat_reg & ien_reg);

    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    sequence s_pin_path(int p);
        pin_edge_reg[p] ##1 flag_reg[p];
    endsequence

    generate
        for (genvar q = 0; q < NPIN; q++) begin : g_ast
            if (PRESENT[q]) begin : g_have
                AST_PIN_FLAG: assert property (
                    pin_det[q] |=> s_pin_path(q))
                    else $error("pin edge did not set flag in two cycles");
            end
            AST_EDGE_OFF: assert property (
                (edge_reg[2*q +: 2] == EDGE_OFF) |-> !pin_det[q])
                else $error("edge seen on disabled pin");
            AST_EDGE_RISE_ONLY: assert property (
                (edge_reg[2*q +: 2] == EDGE_RISE && pin_det[q])
                |-> (pin_s2_reg[q] && $past(pin_s2_reg[q]) == 1'b0))
                else $error("rising select fired on non-rising sample");
            AST_EDGE_FALL_ONLY: assert property (
                (edge_reg[2*q +: 2] == EDGE_FALL && pin_det[q])
                |-> (!pin_s2_reg[q] && $past(pin_s2_reg[q]) == 1'b1))
                else $error("falling select fired on non-falling sample");
            AST_EDGE_BOTH: assert property (
                (edge_reg[2*q +: 2] == EDGE_BOTH && (pin_s2_reg[q] != pin_s3_reg[q]))
                |-> pin_det[q])
                else $error("both-edge select missed a pin change");
        end
    endgenerate

    AST_SMALL_UPPER: assert property (
        (LARGE == 0) |-> (edge_reg[7:EDGE_UPPER_LSB] == 4'h0))
        else $error("small variant upper edge bits nonzero");

    AST_GIE_WR: assert property (
        (wr_acc && sel[0]) |=> (gie_reg == $past(PWDATA[GIE_BIT])))
        else $error("global enable not written");

    AST_BIT7_ZERO: assert property (
        (setup && PADDR == ADDR_FIRST) |=> (PRDATA[7] == 1'b0))
        else $error("first register bit 7 read nonzero");

    AST_SET_WINS: assert property (
        (hw_set != '0) |=> ((flag_reg & $past(hw_set)) == $past(hw_set)))
        else $error("hardware event lost");

    AST_NO_IRQ_GIE: assert property (
        !gie_reg |-> !CPU_IRQ)
        else $error("interrupt with global enable clear");

    AST_DISABLED_QUIET: assert property (
        (wr_acc && sel[1] && !wbyte[EN_LSB]) |=> !CPU_IRQ_VEC[MAP[1][0]])
        else $error("source written disabled still requests");

    AST_MAP_EN_WR: assert property (
        (wr_acc && sel[1]) |=> (en_reg[MAP[1][0]] == $past(wbyte[EN_LSB])))
        else $error("second register slot 0 enable not written");

    AST_MAP_FLAG_RD: assert property (
        (setup && sel[1] && !hw_set[MAP[1][3]]) ##1 1'b1
        |-> (PRDATA[FLAG_LSB + 3] == $past(flag_reg[MAP[1][3]])))
        else $error("second register slot 3 flag read wrong");

    AST_STAT_IRQ: assert property (
        (hw_set[SRC_ADC] && ien_reg[SRC_ADC])
        |=> IRQ ##1 (IRQ || $past(wr_acc && (PADDR == ADDR_CLR || PADDR == ADDR_IEN))))
        else $error("enabled status event did not raise interrupt");

    // Read-back of edge select and global enable
    sequence s_rd_setup(logic [7:0] a);
        setup && (PADDR == a);
    endsequence

    AST_RD_EDGE: assert property (
        s_rd_setup(ADDR_EDGE) |=> (PRDATA[7:0] == $past(edge_reg)))
        else $error("edge select read back wrong");

    AST_GIE_RD: assert property (
        s_rd_setup(ADDR_FIRST) |=> (PRDATA[GIE_BIT] == $past(gie_reg)))
        else $error("global enable read back wrong");

    // Software side of flags and the upper register map
    AST_FLAG_SW_WR: assert property (
        (wr_acc && sel[0] && !hw_set[MAP[0][0]])
        |=> (flag_reg[MAP[0][0]] == $past(wbyte[FLAG_LSB])))
        else $error("first register slot 0 flag not written");

    AST_THIRD_MAP: assert property (
        (wr_acc && sel[2]) |=> (en_reg[MAP[2][3]] == $past(wbyte[EN_LSB + 3])))
        else $error("third register slot 3 enable not written");

    // Status holds until a one is written to the clear register
    AST_STAT_STICKY: assert property (
        !(wr_acc && PADDR == ADDR_CLR)
        |=> ((stat_reg & $past(stat_reg)) == $past(stat_reg)))
        else $error("status bit dropped without a clear");

    AST_CLR_STAT: assert property (
        (wr_acc && PADDR == ADDR_CLR && !hw_set[SRC_CMP0])
        |=> (stat_reg[SRC_CMP0] == ($past(stat_reg[SRC_CMP0]) && !$past(PWDATA[SRC_CMP0]))))
        else $error("status clear of comparator 0 wrong");

endmodule

// ==== rtl/ifb_pkg.sv ====
// Constants, maps and types of the interrupt flag and enable bank.
// Assumes an APB master with 32-bit data; only the low byte is used, except the low 15 bits by the status, clear and status enable registers.
package ifb_pkg;
    // Source numbering shared by flags, enables and status
    localparam int NSRC = 15;
    localparam int NPIN = 4;
    localparam int NMF = 6;
    localparam logic [3:0] SRC_NONE = 4'hf;
    localparam logic [3:0] SRC_PIN0 = 4'h0;
    localparam logic [3:0] SRC_PIN1 = 4'h1;
    localparam logic [3:0] SRC_PIN2 = 4'h2;
    localparam logic [3:0] SRC_PIN3 = 4'h3;
    localparam logic [3:0] SRC_CMP0 = 4'h4;
    localparam logic [3:0] SRC_CMP1 = 4'h5;
    localparam logic [3:0] SRC_ADC = 4'h6;
    localparam logic [3:0] SRC_TB0 = 4'h7;
    localparam logic [3:0] SRC_TB1 = 4'h8;
    localparam logic [3:0] SRC_MF0 = 4'h9;
    localparam logic [3:0] SRC_MF1 = 4'ha;
    localparam logic [3:0] SRC_MF2 = 4'hb;
    localparam logic [3:0] SRC_MF3 = 4'hc;
    localparam logic [3:0] SRC_MF4 = 4'hd;
    localparam logic [3:0] SRC_MF5 = 4'he;
    // Sources that exist in the small and the large variant
    localparam logic [NSRC-1:0] PRESENT_SMALL = 15'h1ff3;
    localparam logic [NSRC-1:0] PRESENT_LARGE = 15'h7fff;
    // Byte addresses on APB
    localparam logic [7:0] ADDR_EDGE = 8'h00;
    localparam logic [7:0] ADDR_FIRST = 8'h04;
    localparam logic [7:0] ADDR_SECOND = 8'h08;
    localparam logic [7:0] ADDR_THIRD = 8'h0c;
    localparam logic [7:0] ADDR_FOURTH = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_CLR = 8'h18;
    localparam logic [7:0] ADDR_IEN = 8'h1c;
    // Field positions
    localparam int GIE_BIT = 0;
    localparam int FIRST_EN_LSB = 1;
    localparam int FLAG_LSB = 4;
    localparam int EN_LSB = 0;
    localparam int EDGE_UPPER_LSB = 4;
    // Reset values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [NSRC-1:0] SRC_RST = 15'h0000;
    // Edge select encoding
    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } ifb_edge_e;
    // Slot map: [register][slot] gives source; first register uses slots 0..2
    typedef logic [3:0] ifb_map_t [0:3][0:3];
    localparam ifb_map_t MAP_SMALL = '{
        '{SRC_PIN0, SRC_PIN1, SRC_CMP0, SRC_NONE},
        '{SRC_CMP1, SRC_MF0, SRC_MF1, SRC_ADC},
        '{SRC_MF2, SRC_TB0, SRC_TB1, SRC_MF3},
        '{SRC_NONE, SRC_NONE, SRC_NONE, SRC_NONE}};
    localparam ifb_map_t MAP_LARGE = '{
        '{SRC_PIN0, SRC_PIN1, SRC_PIN2, SRC_NONE},
        '{SRC_PIN3, SRC_CMP0, SRC_CMP1, SRC_MF0},
        '{SRC_MF1, SRC_MF2, SRC_MF3, SRC_ADC},
        '{SRC_MF4, SRC_TB0, SRC_TB1, SRC_MF5}};
endpackage

// ==== sim/ifb_evt_src.sv ====
// Event source model: peripheral event pulses and external pin levels.
// Assumes callers use it from the bench clock domain.
module ifb_evt_src import ifb_pkg::*; (
    // Clock
    input wire logic clk,
    // Pins and pulses towards the bank
    output logic [ifb_pkg::NPIN-1:0] ext_pin,
    output logic [1:0] cmp_evt,
    output logic adc_evt,
    output logic [1:0] tb_evt,
    output logic [ifb_pkg::NMF-1:0] mf_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet at time zero so no spurious edge follows reset
    initial begin
        ext_pin = '0;
        cmp_evt = '0;
        adc_evt = 1'b0;
        tb_evt = '0;
        mf_evt = '0;
    end

    // One-cycle pulse, source index order; pin bits ignored
    task automatic pulse(input logic [NSRC-1:0] e);
        @(posedge clk);
        cmp_evt <= e[5:4];
        adc_evt <= e[6];
        tb_evt <= e[8:7];
        mf_evt <= e[14:9];
        @(posedge clk);
        cmp_evt <= '0;
        adc_evt <= 1'b0;
        tb_evt <= '0;
        mf_evt <= '0;
    endtask

    // Pins are levels; the bank finds the edges itself
    task automatic set_pins(input logic [NPIN-1:0] p);
        @(posedge clk);
        ext_pin <= p;
    endtask
endmodule

// ==== sim/tb_top.sv ====
// Bench: small and large banks on one APB bus, checked against a model.
// Assumes ifb_evt_src drives the event inputs of both banks.
`define CHK(got, exp) \
    checks_done++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("Error %0t: got %h expected %h", $time, got, exp); \
    end
module tb_top import ifb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] rdata [2], got_rd [2];
    logic ready [2], slverr [2], got_err [2], cpu_irq [2], irq [2];
    logic [NSRC-1:0] irq_vec [2];
    logic [NPIN-1:0] ext_pin, pins_now;
    logic [1:0] cmp_evt, tb_evt;
    logic adc_evt;
    logic [NMF-1:0] mf_evt;
    int error_cnt = 0;
    int checks_done = 0;
    int seed_q;
    // Bench model state, index 0 small, 1 large
    logic [NSRC-1:0] flg [2], en [2], stat [2], ien [2], pres [2];
    logic [7:0] edge_sel [2];
    logic gie [2];
    logic [7:0] addrs [9] = '{ADDR_EDGE, ADDR_FIRST, ADDR_SECOND, ADDR_THIRD,
        ADDR_FOURTH, ADDR_STAT, ADDR_CLR, ADDR_IEN, 8'h20};
    // Source in flag bit 4+k of each register; 15 marks no source
    int srcmap [2][5][4] = '{
        '{'{15, 15, 15, 15}, '{0, 1, 4, 15}, '{5, 9, 10, 6}, '{11, 7, 8, 12},
          '{15, 15, 15, 15}},
        '{'{15, 15, 15, 15}, '{0, 1, 2, 15}, '{3, 4, 5, 9}, '{10, 11, 12, 6},
          '{13, 7, 8, 14}}};

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    for (genvar v = 0; v < 2; v++) begin : g_bank
        ifb_bank #(.LARGE(v)) ifb_bank_inst (.CLK(clk), .RSTN(rstn), .PSEL(psel),
            .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
            .PRDATA(rdata[v]), .PREADY(ready[v]), .PSLVERR(slverr[v]),
            .EXT_PIN(ext_pin), .CMP_EVT(cmp_evt), .ADC_EVT(adc_evt), .TB_EVT(tb_evt),
            .MF_EVT(mf_evt), .CPU_IRQ(cpu_irq[v]), .CPU_IRQ_VEC(irq_vec[v]),
            .IRQ(irq[v]));
    end

    ifb_evt_src ifb_evt_src_inst (.clk(clk), .ext_pin(ext_pin), .cmp_evt(cmp_evt),
        .adc_evt(adc_evt), .tb_evt(tb_evt), .mf_evt(mf_evt));

    // Expected register image from the model
    function automatic logic [31:0] exp_reg(int v, int r);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (r == 0)
            d[7:0] = edge_sel[v];
        if (r == 5)
            d[NSRC-1:0] = stat[v];
        if (r == 7)
            d[NSRC-1:0] = ien[v];
        for (int k = 0; k < 4 && r > 0 && r < 5; k++) begin
            if (srcmap[v][r][k] < NSRC) begin
                d[4 + k] = flg[v][srcmap[v][r][k]];
                d[k + (r == 1)] = en[v][srcmap[v][r][k]];
            end
        end
        if (r == 1)
            d[0] = gie[v];
        return d;
    endfunction

    // Hardware events set flag and status, absent sources never
    function automatic void mdl_event(logic [NSRC-1:0] e);
        for (int v = 0; v < 2; v++) begin
            flg[v] |= e & pres[v];
            stat[v] |= e & pres[v];
        end
    endfunction

    // Edge field bit 0 selects rising, bit 1 falling
    function automatic void mdl_pins(logic [3:0] o, logic [3:0] n);
        logic [NSRC-1:0] hit;
        for (int v = 0; v < 2; v++) begin
            hit = '0;
            for (int p = 0; p < NPIN; p++) begin
                hit[p] = (edge_sel[v][2*p] && !o[p] && n[p]) ||
                    (edge_sel[v][2*p+1] && o[p] && !n[p]);
            end
            flg[v] |= hit & pres[v];
            stat[v] |= hit & pres[v];
        end
    endfunction

    // One APB transfer; bounded wait for ready on both slaves
    task automatic apb(input logic wr, input int r, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addrs[r];
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!(ready[0] === 1'b1 && ready[1] === 1'b1) && n < 50);
        if (n >= 50) begin
            error_cnt++;
            $display("Error %0t: no ready", $time);
        end
        for (int v = 0; v < 2; v++) begin
            got_rd[v] = rdata[v];
            got_err[v] = slverr[v];
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write through the bus and into the model
    task automatic wr(input int r, input logic [31:0] d);
        apb(1'b1, r, d);
        for (int v = 0; v < 2; v++) begin
            if (r == 0)
                edge_sel[v] = v ? d[7:0] : {4'h0, d[3:0]};
            if (r == 1)
                gie[v] = d[0];
            for (int k = 0; k < 4 && r > 0 && r < 5; k++) begin
                if (srcmap[v][r][k] < NSRC) begin
                    flg[v][srcmap[v][r][k]] = d[4 + k];
                    en[v][srcmap[v][r][k]] = d[k + (r == 1)];
                end
            end
            if (r == 6)
                stat[v] &= ~d[NSRC-1:0];
            if (r == 7)
                ien[v] = d[NSRC-1:0];
        end
    endtask

    // Read every register and compare all outputs
    task automatic check_all();
        for (int r = 0; r < 8; r++) begin
            apb(1'b0, r, 32'h0000_0000);
            for (int v = 0; v < 2; v++) begin
                `CHK(got_rd[v], exp_reg(v, r))
                `CHK(got_err[v], 1'(v == 0 && r == 4))
            end
        end
        for (int v = 0; v < 2; v++) begin
            `CHK(cpu_irq[v], gie[v] & (|(flg[v] & en[v])))
            `CHK(irq_vec[v], flg[v] & en[v])
            `CHK(irq[v], 1'(|(stat[v] & ien[v])))
        end
    endtask

    // Pin change, then enough edges for sampling and flag set
    task automatic drive_pins(input logic [3:0] n);
        ifb_evt_src_inst.set_pins(n);
        repeat (5) @(posedge clk);
        mdl_pins(pins_now, n);
        pins_now = n;
        check_all();
    endtask

    task automatic end_sim();
        $display("Counts: %0d checks, %0d errors", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog well above the under two thousand cycles the tests need
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        logic [NSRC-1:0] e;
        {rstn, psel, penable, pwrite, paddr, pwdata, pins_now} = '0;
        for (int v = 0; v < 2; v++) begin
            {flg[v], en[v], stat[v], ien[v], pres[v], edge_sel[v], gie[v]} = '0;
            for (int r = 1; r < 5; r++)
                for (int k = 0; k < 4; k++)
                    if (srcmap[v][r][k] < NSRC)
                        pres[v][srcmap[v][r][k]] = 1'b1;
        end
        seed_q = $urandom(74591);
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        check_all();
        $display("Test reset values done");
        // Random layouts, read-only bit 7, stray writes
        wr(1, 32'h0000_00ff);
        for (int i = 0; i < 3; i++)
            for (int r = 0; r < 5; r++)
                wr(r, $urandom());
        apb(1'b1, 5, $urandom());
        for (int v = 0; v < 2; v++) begin
            `CHK(got_err[v], 1'b0)
        end
        apb(1'b1, 8, 32'h0000_00ff);
        for (int v = 0; v < 2; v++) begin
            `CHK(got_err[v], 1'b1)
        end
        check_all();
        $display("Test register layout done");
        // Events set flags whatever the enables; global enable gates
        for (int i = 0; i < 6; i++) begin
            wr(1 + i % 4, $urandom());
            wr(1, {$urandom() & 32'hffff_fffe} | 32'(i % 2));
            e = 15'($urandom()) & 15'h7ff0;
            ifb_evt_src_inst.pulse(e);
            mdl_event(e);
            check_all();
        end
        $display("Test events done");
        // Status interrupt: raise, mask, clear
        wr(7, 32'h0000_7fff);
        check_all();
        wr(7, 32'h0000_0000);
        ifb_evt_src_inst.pulse(15'h0210);
        mdl_event(15'h0210);
        check_all();
        wr(7, 32'h0000_7fff);
        check_all();
        ifb_evt_src_inst.pulse(15'h0040);
        mdl_event(15'h0040);
        check_all();
        wr(6, 32'h0000_7fff);
        check_all();
        $display("Test status interrupt done");
        // Every edge mode on every pin
        for (int p = 0; p < NPIN; p++) begin
            for (int m = 0; m < 4; m++) begin
                for (int r = 1; r < 5; r++)
                    wr(r, 32'h0000_0000);
                wr(0, 32'(m) << (2 * p));
                drive_pins(4'(1 << p));
                drive_pins(4'h0);
            end
        end
        $display("Test pin edges done");
        end_sim();
    end
endmodule
